// [common/pmr_pkg.sv]
// Purpose: shared constants and carriers for the power monitor result and alert bank
// Assumes: 4-bit register addresses, 16-bit write data, 40-bit read data
// Notes: narrower registers sit in the low bits of the read word, except bus voltage and current, which sit above 4 reserved zero LSBs
`default_nettype none
package pmr_pkg;
  // ***********************************************************
  // register addresses
  // ***********************************************************
  localparam logic [3:0] ADDR_BUS_VOLTAGE = 4'h5;
  localparam logic [3:0] ADDR_DIE_TEMP = 4'h6;
  localparam logic [3:0] ADDR_CURRENT = 4'h7;
  localparam logic [3:0] ADDR_POWER = 4'h8;
  localparam logic [3:0] ADDR_ENERGY = 4'h9;
  localparam logic [3:0] ADDR_CHARGE = 4'hA;
  localparam logic [3:0] ADDR_DIAG_ALERT = 4'hB;

  // ***********************************************************
  // diagnostic and alert register layout
  // ***********************************************************
  localparam int BIT_ALERT_LATCH = 15;
  localparam int BIT_READY_TO_ALERT = 14;
  localparam int BIT_COMPARE_AVG = 13;
  localparam int BIT_ALERT_POL = 12;
  localparam int BIT_ENERGY_OVF = 11;
  localparam int BIT_CONV_DONE = 1;
  localparam int BIT_MEM_OK = 0;
  localparam logic [15:0] DIAG_RESET = 16'h0001;
  localparam int RESERVED_LSBS = 4;
  localparam logic [39:0] UNMAPPED_READ = 40'h00_0000_0000;

  // ***********************************************************
  // carriers
  // ***********************************************************
  typedef struct packed {
    logic [19:0] busVoltage;
    logic [15:0] die_temperature_result;
    logic [19:0] current;
    logic [23:0] power;
    logic [39:0] energy;
    logic [39:0] charge;
  } pmr_meas_t;

  localparam pmr_meas_t MEAS_RESET = '0;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [15:0] wdata;
  } pmr_req_t;
endpackage
`default_nettype wire

// [design/pmr_result_alert_regs.sv]
// Purpose: result registers plus alert configuration and flags of a power monitor
// Assumes: serial front end delivers one-cycle register requests on clk
// Notes: alert pin is open drain; the pin output is held low and only its enable moves
`default_nettype none
module pmr_result_alert_regs
  import pmr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire pmr_pkg::pmr_req_t req,
  output logic [39:0] rdData,
  output logic rdValid,
  input wire pmr_pkg::pmr_meas_t measIn,
  input wire logic sampleDone,
  input wire logic avgDone,
  input wire logic [2:0] averagingCount,
  input wire logic rawFault,
  input wire logic avgFault,
  input wire logic convStart,
  input wire logic energyOverflow,
  input wire logic accumulatorReset,
  input wire logic memChecksumError,
  output logic alertPinOut,
  output logic alertPinOeN
);
  import pmr_pkg::*;

  // ***********************************************************
  // state
  // ***********************************************************
  pmr_meas_t meas_r;
  logic [39:0] rdData_r;
  logic rdValid_r;
  logic alertLatchEnable_r;
  logic readyToAlertEnable_r;
  logic compareOnAveraged_r;
  logic alertPolarity_r;
  logic energyOverflowFlag_r;
  logic conversionCompleteFlag_r;
  logic memOk_r;
  logic faultLevel_r;
  logic alertFlag_r;
  logic alertPinOeN_r;

  // ***********************************************************
  // decode
  // ***********************************************************
  wire logic diagRead = req.rd && (req.addr == ADDR_DIAG_ALERT);
  wire logic diagWrite = req.wr && (req.addr == ADDR_DIAG_ALERT);
  // averaging off means every sample is already a finished result
  wire logic resultUpdate = avgDone || (sampleDone && (averagingCount == 3'h0));
  wire logic convDone = resultUpdate;

  wire logic alertLatchEnable_nxt =
    diagWrite ? req.wdata[BIT_ALERT_LATCH] : alertLatchEnable_r;
  wire logic readyToAlertEnable_nxt =
    diagWrite ? req.wdata[BIT_READY_TO_ALERT] : readyToAlertEnable_r;
  wire logic compareOnAveraged_nxt =
    diagWrite ? req.wdata[BIT_COMPARE_AVG] : compareOnAveraged_r;
  wire logic alertPolarity_nxt =
    diagWrite ? req.wdata[BIT_ALERT_POL] : alertPolarity_r;

  // fault level moves only on the result that the comparison mode picks
  wire logic faultEvent = compareOnAveraged_r ? avgDone : sampleDone;
  wire logic faultSample = compareOnAveraged_r ? avgFault : rawFault;
  wire logic faultLevel_nxt = faultEvent ? faultSample : faultLevel_r;

  // set beats clear for both hardware flags
  wire logic energyOverflowFlag_nxt =
    energyOverflow || (energyOverflowFlag_r && !accumulatorReset);
  wire logic ccfClear =
    convStart || (diagRead && alertLatchEnable_r) || (!alertLatchEnable_r && sampleDone);
  wire logic conversionCompleteFlag_nxt =
    convDone || (conversionCompleteFlag_r && !ccfClear);

  wire logic alertCause =
    faultLevel_nxt || (readyToAlertEnable_r && conversionCompleteFlag_nxt);
  wire logic alertFlag_nxt = alertLatchEnable_r ?
    (alertCause || (alertFlag_r && !diagRead)) :
    alertCause;
  // active-low drives while asserted, active-high drives while idle
  wire logic alertPinOeN_nxt = !(alertFlag_nxt ^ alertPolarity_nxt);

  wire logic [15:0] diagValue = {alertLatchEnable_r, readyToAlertEnable_r,
    compareOnAveraged_r, alertPolarity_r, energyOverflowFlag_r, 9'h000,
    conversionCompleteFlag_r, memOk_r};

  wire logic [39:0] busVoltageWord =
    {16'h0000, meas_r.busVoltage, {RESERVED_LSBS{1'b0}}};
  wire logic [39:0] dieTempWord = {24'h00_0000, meas_r.die_temperature_result};
  wire logic [39:0] currentWord =
    {16'h0000, meas_r.current, {RESERVED_LSBS{1'b0}}};
  wire logic [39:0] powerWord = {16'h0000, meas_r.power};
  wire logic [39:0] diagWord = {24'h00_0000, diagValue};

  wire logic [39:0] rdMux =
    (req.addr == ADDR_BUS_VOLTAGE) ? busVoltageWord :
    (req.addr == ADDR_DIE_TEMP) ? dieTempWord :
    (req.addr == ADDR_CURRENT) ? currentWord :
    (req.addr == ADDR_POWER) ? powerWord :
    (req.addr == ADDR_ENERGY) ? meas_r.energy :
    (req.addr == ADDR_CHARGE) ? meas_r.charge :
    (req.addr == ADDR_DIAG_ALERT) ? diagWord :
    UNMAPPED_READ;

  // ***********************************************************
  // registers
  // ***********************************************************
  // whole struct loads in one edge, so a snapshot never mixes two results
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meas_r <= MEAS_RESET;
    end
    else if (ce)
    begin
      if (resultUpdate)
      begin
        meas_r <= measIn;
      end
    end
  end

  // read data is captured whole; the serial side shifts it out later
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdData_r <= UNMAPPED_READ;
      rdValid_r <= 1'b0;
    end
    else if (ce)
    begin
      rdValid_r <= req.rd;
      if (req.rd)
      begin
        rdData_r <= rdMux;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      alertLatchEnable_r <= DIAG_RESET[BIT_ALERT_LATCH];
      readyToAlertEnable_r <= DIAG_RESET[BIT_READY_TO_ALERT];
      compareOnAveraged_r <= DIAG_RESET[BIT_COMPARE_AVG];
      alertPolarity_r <= DIAG_RESET[BIT_ALERT_POL];
      energyOverflowFlag_r <= DIAG_RESET[BIT_ENERGY_OVF];
      conversionCompleteFlag_r <= DIAG_RESET[BIT_CONV_DONE];
      memOk_r <= DIAG_RESET[BIT_MEM_OK];
    end
    else if (ce)
    begin
      alertLatchEnable_r <= alertLatchEnable_nxt;
      readyToAlertEnable_r <= readyToAlertEnable_nxt;
      compareOnAveraged_r <= compareOnAveraged_nxt;
      alertPolarity_r <= alertPolarity_nxt;
      energyOverflowFlag_r <= energyOverflowFlag_nxt;
      conversionCompleteFlag_r <= conversionCompleteFlag_nxt;
      memOk_r <= memOk_r && !memChecksumError;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      faultLevel_r <= 1'b0;
      alertFlag_r <= 1'b0;
      alertPinOeN_r <= 1'b1;
    end
    else if (ce)
    begin
      faultLevel_r <= faultLevel_nxt;
      alertFlag_r <= alertFlag_nxt;
      alertPinOeN_r <= alertPinOeN_nxt;
    end
  end

  assign rdData = rdData_r;
  assign rdValid = rdValid_r;
  assign alertPinOeN = alertPinOeN_r;
  // open drain: the driven level is always low
  assign alertPinOut = 1'b0;

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  sequence s_read(logic [3:0] a);
    ce && req.rd && (req.addr == a);
  endsequence

  sequence s_diagRead;
    ce && diagRead;
  endsequence

  property p_busVoltage;
    s_read(ADDR_BUS_VOLTAGE) |=>
      rdData_r == {16'h0000, $past(meas_r.busVoltage), 4'h0};
  endproperty
  a_busVoltage: assert property (p_busVoltage)
    else $error("bus voltage read wrong");

  property p_die_temperature_result;
    s_read(ADDR_DIE_TEMP) |=> rdData_r == {24'h00_0000, $past(meas_r.die_temperature_result)};
  endproperty
  a_die_temperature_result: assert property (p_die_temperature_result)
    else $error("die temperature read wrong");

  property p_current;
    s_read(ADDR_CURRENT) |=>
      (rdData_r[3:0] == 4'h0) && (rdData_r[23:4] == $past(meas_r.current));
  endproperty
  a_current: assert property (p_current)
    else $error("current read wrong");

  property p_power;
    s_read(ADDR_POWER) |=> rdData_r == {16'h0000, $past(meas_r.power)};
  endproperty
  a_power: assert property (p_power)
    else $error("power read wrong");

  property p_energyCharge;
    s_read(ADDR_ENERGY) or s_read(ADDR_CHARGE) |=>
      rdData_r == ($past(req.addr) == ADDR_ENERGY ? $past(meas_r.energy)
                                                   : $past(meas_r.charge));
  endproperty
  a_energyCharge: assert property (p_energyCharge)
    else $error("accumulator read wrong");

  property p_transparentIdle;
    !alertLatchEnable_r && !faultLevel_nxt && !alertCause |=> !alertFlag_r;
  endproperty
  a_transparentIdle: assert property (p_transparentIdle)
    else $error("transparent alert did not go idle");

  property p_latchedHold;
    alertLatchEnable_r && alertFlag_r && !diagRead |=> alertFlag_r;
  endproperty
  a_latchedHold: assert property (p_latchedHold)
    else $error("latched alert dropped without a read");

  property p_latchedClear;
    alertLatchEnable_r && diagRead && !alertCause |=> !alertFlag_r;
  endproperty
  a_latchedClear: assert property (p_latchedClear)
    else $error("latched alert not released by read");

  property p_readyRouting;
    readyToAlertEnable_r && convDone |=> alertFlag_r && conversionCompleteFlag_r;
  endproperty
  a_readyRouting: assert property (p_readyRouting)
    else $error("conversion complete not routed to alert");

  property p_rawIgnored;
    compareOnAveraged_r && !avgDone |=> faultLevel_r == $past(faultLevel_r);
  endproperty
  a_rawIgnored: assert property (p_rawIgnored)
    else $error("fault moved on a raw sample in averaged mode");

  property p_polarity;
    alertPinOeN_r == !(alertFlag_r ^ alertPolarity_r);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("alert pin polarity wrong");

  property p_energyOvf;
    energyOverflow |=> energyOverflowFlag_r;
  endproperty
  a_energyOvf: assert property (p_energyOvf)
    else $error("energy overflow flag lost");

  // only an accumulator reset may take the flag down
  property p_energyHold;
    energyOverflowFlag_r && !accumulatorReset |=> energyOverflowFlag_r;
  endproperty
  a_energyHold: assert property (p_energyHold)
    else $error("energy overflow flag dropped without reset");

  property p_energyClear;
    accumulatorReset && !energyOverflow |=> !energyOverflowFlag_r;
  endproperty
  a_energyClear: assert property (p_energyClear)
    else $error("energy overflow flag not cleared");

  property p_diagReset;
    $past(rst) |-> diagValue == DIAG_RESET;
  endproperty
  a_diagReset: assert property (p_diagReset)
    else $error("diagnostic register reset value wrong");

  property p_ccfLatchedClear;
    s_diagRead ##0 (alertLatchEnable_r && !convDone) |=> !conversionCompleteFlag_r;
  endproperty
  a_ccfLatchedClear: assert property (p_ccfLatchedClear)
    else $error("conversion complete flag not cleared by read");

  property p_avgHold;
    (averagingCount != 3'h0) && !avgDone |=> $stable(meas_r);
  endproperty
  a_avgHold: assert property (p_avgHold)
    else $error("results updated mid averaging");

  property p_readPulse;
    ce |=> rdValid_r == $past(req.rd);
  endproperty
  a_readPulse: assert property (p_readPulse)
    else $error("read valid pulse wrong");

  // ce low must freeze everything, so the default disable is overridden here
  property p_ceFreeze;
    disable iff (rst)
    !ce |=> $stable(meas_r) && $stable(diagValue) && $stable(rdData_r) && $stable(rdValid_r)
      && $stable(faultLevel_r) && $stable(alertFlag_r) && $stable(alertPinOeN_r);
  endproperty
  a_ceFreeze: assert property (p_ceFreeze)
    else $error("state moved while clock enable was low");
endmodule
`default_nettype wire

// [verification/pmr_alert_host.sv]
// Purpose: host side of the open-drain alert line
// Assumes: a pull-up on the board holds the line high when released
// Notes: a released line reads the pull-up level, never the last driven value
`default_nettype none
module pmr_alert_host
(
  input wire logic pinOut,
  input wire logic pinOeN,
  output logic pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up wins whenever the device lets go
  assign pinLevel = pinOeN ? 1'b1 : pinOut;
endmodule
`default_nettype wire

// [verification/pmr_result_alert_regs_tb.sv]
// Purpose: self-checking bench for the result and alert register bank
// Assumes: inputs change on the falling edge; read answer one cycle after the request
// Notes: the alert pin is judged through the host model with its pull-up
`default_nettype none
module pmr_result_alert_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmr_pkg::*;
  localparam logic [5:0] EV_S = 6'h20;
  localparam logic [5:0] EV_A = 6'h10;
  localparam logic [5:0] EV_C = 6'h08;
  localparam logic [5:0] EV_EO = 6'h04;
  localparam logic [5:0] EV_AR = 6'h02;
  localparam logic [5:0] EV_MC = 6'h01;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic rawFault = 1'b0;
  logic avgFault = 1'b0;
  logic [5:0] evBus = 6'h00;
  logic [2:0] averagingCount = 3'h0;
  logic [39:0] rdData;
  logic rdValid;
  logic alertPinOut;
  logic alertPinOeN;
  logic pinLevel;
  pmr_req_t req = '0;
  pmr_meas_t measIn = MEAS_RESET;
  int errCount = 0;
  int checked = 0;

  pmr_result_alert_regs dut_u (
    .clk(clk), .rst(rst), .ce(ce), .req(req), .rdData(rdData), .rdValid(rdValid),
    .measIn(measIn), .sampleDone(evBus[5]), .avgDone(evBus[4]),
    .averagingCount(averagingCount), .rawFault(rawFault), .avgFault(avgFault),
    .convStart(evBus[3]), .energyOverflow(evBus[2]), .accumulatorReset(evBus[1]),
    .memChecksumError(evBus[0]), .alertPinOut(alertPinOut), .alertPinOeN(alertPinOeN)
  );

  pmr_alert_host host_u (.pinOut(alertPinOut), .pinOeN(alertPinOeN), .pinLevel(pinLevel));

  // ***********************************************************
  // access tasks
  // ***********************************************************
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      errCount++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [39:0] exp);
    req = '{1'b1, 1'b0, a, 16'h0000};
    @(negedge clk);
    req = '0;
    chk({39'h0, rdValid}, 40'h1, "read valid");
    chk(rdData, exp, "read data");
    @(negedge clk);
    // valid is a single-cycle pulse
    chk({39'h0, rdValid}, 40'h0, "read valid drop");
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    req = '{1'b0, 1'b1, a, d};
    @(negedge clk);
    req = '0;
    @(negedge clk);
  endtask

  // one-cycle event pulse, then a settle cycle before anything is judged
  task automatic ev(input logic [5:0] m);
    evBus = m;
    @(negedge clk);
    evBus = 6'h00;
    @(negedge clk);
  endtask

  task automatic pin(input logic exp);
    chk({39'h0, pinLevel}, {39'h0, exp}, "alert pin");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ***********************************************************
  // clock, watchdog, tests
  // ***********************************************************
  initial
  begin
    forever #10 clk = ~clk;
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    errCount++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    finish_test();
  end

  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rd(ADDR_DIAG_ALERT, 40'h0001);
    for (int a = 5; a < 11; a++)
    begin
      rd(4'(a), 40'h0);
    end
    rd(4'h0, 40'h0);
    wr(ADDR_DIAG_ALERT, 16'hFFFF);
    rd(ADDR_DIAG_ALERT, 40'hF001);
    wr(ADDR_DIAG_ALERT, 16'h0000);
    ev(EV_EO);
    rd(ADDR_DIAG_ALERT, 40'h0801);
    ev(EV_AR);
    rd(ADDR_DIAG_ALERT, 40'h0001);
    $display("reset and flag test done");
    measIn = '{20'h7ABCD, 16'hF123, 20'h81234, 24'hFEDCBA, 40'hFF01234567, 40'h8000000001};
    ev(EV_S);
    wr(ADDR_POWER, 16'hFFFF);
    rd(ADDR_BUS_VOLTAGE, {16'h0, measIn.busVoltage, 4'h0});
    rd(ADDR_DIE_TEMP, {24'h0, measIn.die_temperature_result});
    rd(ADDR_CURRENT, {16'h0, measIn.current, 4'h0});
    rd(ADDR_POWER, {16'h0, measIn.power});
    rd(ADDR_ENERGY, measIn.energy);
    rd(ADDR_CHARGE, measIn.charge);
    averagingCount = 3'h2;
    measIn.power = 24'h123456;
    ev(EV_S);
    rd(ADDR_POWER, 40'hFEDCBA);
    ev(EV_A);
    rd(ADDR_POWER, 40'h123456);
    averagingCount = 3'h0;
    $display("result test done");
    rawFault = 1'b1;
    ev(EV_S);
    pin(1'b0);
    rawFault = 1'b0;
    ev(EV_S);
    pin(1'b1);
    wr(ADDR_DIAG_ALERT, 16'h1000);
    pin(1'b0);
    rawFault = 1'b1;
    ev(EV_S);
    pin(1'b1);
    rawFault = 1'b0;
    ev(EV_S);
    wr(ADDR_DIAG_ALERT, 16'h2000);
    avgFault = 1'b1;
    ev(EV_S);
    pin(1'b1);
    ev(EV_A);
    pin(1'b0);
    avgFault = 1'b0;
    ev(EV_A);
    pin(1'b1);
    ev(EV_C);
    wr(ADDR_DIAG_ALERT, 16'h4000);
    pin(1'b1);
    ev(EV_S);
    pin(1'b0);
    ev(EV_C);
    pin(1'b1);
    wr(ADDR_DIAG_ALERT, 16'h8000);
    rawFault = 1'b1;
    ev(EV_S);
    rawFault = 1'b0;
    ev(EV_S);
    pin(1'b0);
    rd(ADDR_DIAG_ALERT, 40'h8003);
    pin(1'b1);
    rd(ADDR_DIAG_ALERT, 40'h8001);
    ev(EV_MC);
    rd(ADDR_DIAG_ALERT, 40'h8000);
    $display("alert test done");
    // events while ce is low must be lost, not deferred
    ce = 1'b0;
    ev(EV_EO);
    rawFault = 1'b1;
    measIn.power = 24'h0ABCDE;
    ev(EV_S);
    pin(1'b1);
    rawFault = 1'b0;
    ce = 1'b1;
    rd(ADDR_DIAG_ALERT, 40'h8000);
    rd(ADDR_POWER, 40'h123456);
    // second reset in mid-run brings the whole bank back
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(ADDR_DIAG_ALERT, 40'h0001);
    rd(ADDR_ENERGY, 40'h0);
    pin(1'b1);
    $display("clock enable and reset test done");
    finish_test();
  end
endmodule
`default_nettype wire
